// ### fpes_pkg.sv
package fpes_pkg;
   // ====================================================
   // register map (word indices on the plain port)
   localparam logic [3:0]  ADDR_CTRL      = 4'h0;
   localparam logic [3:0]  ADDR_KEY       = 4'h1;
   localparam logic [3:0]  ADDR_PAGE      = 4'h2;
   localparam logic [3:0]  ADDR_STATUS    = 4'h3;
   // ====================================================
   // control field positions
   localparam int          BIT_START      = 15;
   localparam int          BIT_ENABLE     = 14;
   localparam int          BIT_ERR        = 13;
   localparam int          BIT_ERASE      = 6;
   localparam logic [15:0] CTRL_IMPL_MASK = 16'hE04F;
   localparam logic [15:0] CTRL_RESET     = 16'h0000;
   // ====================================================
   // unlock keys and operation codes
   localparam logic [7:0]  KEY_FIRST      = 8'h55;
   localparam logic [7:0]  KEY_SECOND     = 8'hAA;
   localparam logic [3:0]  OP_BULK        = 4'hF;
   localparam logic [3:0]  OP_WORD        = 4'h3;
   localparam logic [3:0]  OP_BLOCK       = 4'h2;
   localparam logic [3:0]  OP_ROW         = 4'h1;
   // ====================================================
   // geometry, bytes
   localparam int          ROW_BYTES      = 192;
   localparam int          BLOCK_BYTES    = 1536;
   // ====================================================
   // self-timed operation lengths, microseconds
   localparam int          CLK_MHZ        = 50;
   localparam int          T_WORD_US      = 40;
   localparam int          T_ROW_US       = 2000;
   localparam int          T_ERASE_US     = 20000;
   localparam int          CYC_WORD       = T_WORD_US * CLK_MHZ;
   localparam int          CYC_ROW        = T_ROW_US * CLK_MHZ;
   localparam int          CYC_ERASE      = T_ERASE_US * CLK_MHZ;
   localparam int          CYC_NOP        = 1;

   typedef enum logic [1:0] {
      FPES_LOCKED = 2'b00,
      FPES_KEY1   = 2'b01,
      FPES_OPEN   = 2'b10
   } fpes_unlock_t;

   typedef enum logic [2:0] {
      FPES_OP_NONE  = 3'b000,
      FPES_OP_WORD  = 3'b001,
      FPES_OP_ROW   = 3'b010,
      FPES_OP_BLOCK = 3'b011,
      FPES_OP_BULK  = 3'b100
   } fpes_op_t;
endpackage

// ### fpes_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// down counter for the self-timed operation
module fpes_timer #(
   parameter int W = 21
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   output logic              busy,
   output logic              done
);
   logic [W-1:0] cnt_q;

   initial begin
      if (W < 2 || W > 31) $error("fpes_timer: W out of range");
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            cnt_q <= count;
            busy  <= 1'b1;
         end else if (busy) begin
            if (cnt_q <= W'(1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_q <= cnt_q - W'(1);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### fpes_seq.sv
// Function
// RL1 - keys 55h then AAh on consecutive writes unlock one start request
// RL2 - key register is write-only; reads return zero
// RL3 - processor stall held high for the whole operation
// RL4 - start bit 15 set-only by software, cleared by hardware at end
// RL5 - enable bit 14 low inhibits every program and erase
// RL6 - error bit 13 set on improper sequence or termination; the code sets it only on a refused start
// RL7 - erase-select bit 6 picks erase or program for the next start
// RL8 - erase with code 1111 is bulk, 0010 is eight-row block erase
// RL9 - program with code 0011 is one word, 0001 is one row
// RL10 - other operation codes perform no flash operation
// RL11 - bulk erase only in serial programming mode
// RL12 - control bits cleared by power-on reset only
// RL13 - bits 12..7 and 5..4 read as zero
// RL14 - software sets code, erase, enable, address, keys, then start
// RL15 - software does one dummy table write inside the block before erase
// RL16 - software fills 64 latches, selects row program, unlocks, starts
// RL17 - software saves and restores the 512-instruction block around erase
// RL18 - software places two no-ops after setting start
// RL19 - software masks interrupts below 7 over the five key instructions
// RL20 - table writes only fill holding latches until an operation
// RL21 - blocks align on 1536 bytes, rows on 192 bytes
// RL22 - 24-bit address is page register over 16-bit effective address
// RL23 - any wrong or intervening write relocks the unlock checker
// RL24 - start without unlock or enable is refused and sets the error
`timescale 1ns/1ps
`default_nettype none
module fpes_seq #(
   parameter int CYC_WORD  = fpes_pkg::CYC_WORD,
   parameter int CYC_ROW   = fpes_pkg::CYC_ROW,
   parameter int CYC_ERASE = fpes_pkg::CYC_ERASE
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   input  wire logic        tbl_wr,
   input  wire logic [15:0] tbl_ea,
   input  wire logic        serial_programming_mode,
   output logic             cpu_stall,
   output logic             latch_wr,
   output logic [23:0]      latch_addr,
   output logic             flash_word,
   output logic             flash_row,
   output logic             flash_block,
   output logic             flash_bulk,
   output logic [23:0]      flash_addr
);
   localparam int TW = 21;

   initial begin
      if (CYC_WORD < 1 || CYC_ROW < 1 || CYC_ERASE < 1 || CYC_ERASE >= (1 << TW))
         $error("fpes_seq: operation lengths out of range");
   end

   // ====================================================
   // state
   logic                 start_q;
   logic                 enable_q;
   logic                 err_q;
   logic                 erase_q;
   logic [3:0]           op_q;
   logic [7:0]           page_q;
   logic [23:0]          base_q;
   fpes_pkg::fpes_unlock_t unlock_q;
   fpes_pkg::fpes_op_t   op_d;
   logic                 tmr_load;
   logic                 tmr_busy;
   logic                 tmr_done;
   logic [TW-1:0]        tmr_count;

   wire wr_ctrl  = reg_wr && reg_addr == fpes_pkg::ADDR_CTRL;
   wire wr_key   = reg_wr && reg_addr == fpes_pkg::ADDR_KEY;
   wire wr_page  = reg_wr && reg_addr == fpes_pkg::ADDR_PAGE;
   wire start_rq = wr_ctrl && reg_wdata[fpes_pkg::BIT_START] && !start_q;
   wire go       = start_rq && unlock_q == fpes_pkg::FPES_OPEN && enable_q; // see RL1 see RL5

   // ====================================================
   // operation decode from erase-select and code
   always_comb begin
      op_d = fpes_pkg::FPES_OP_NONE; // see RL10
      if (erase_q) begin // see RL7
         if (op_q == fpes_pkg::OP_BULK && serial_programming_mode)
            op_d = fpes_pkg::FPES_OP_BULK; // see RL8 see RL11
         else if (op_q == fpes_pkg::OP_BLOCK)
            op_d = fpes_pkg::FPES_OP_BLOCK; // see RL8
      end else begin
         if (op_q == fpes_pkg::OP_WORD)
            op_d = fpes_pkg::FPES_OP_WORD; // see RL9
         else if (op_q == fpes_pkg::OP_ROW)
            op_d = fpes_pkg::FPES_OP_ROW; // see RL9
      end
   end

   always_comb begin
      unique case (op_d)
         fpes_pkg::FPES_OP_WORD:  tmr_count = TW'(CYC_WORD);
         fpes_pkg::FPES_OP_ROW:   tmr_count = TW'(CYC_ROW);
         fpes_pkg::FPES_OP_BLOCK: tmr_count = TW'(CYC_ERASE);
         fpes_pkg::FPES_OP_BULK:  tmr_count = TW'(CYC_ERASE);
         default:                 tmr_count = TW'(fpes_pkg::CYC_NOP);
      endcase
   end

   assign tmr_load = go;

   fpes_timer #(
      .W (TW)
   ) u_timer (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .load    (tmr_load),
      .count   (tmr_count),
      .busy    (tmr_busy),
      .done    (tmr_done)
   );

   // ====================================================
   // unlock checker: only the keys on consecutive bus writes count
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         unlock_q <= fpes_pkg::FPES_LOCKED;
      end else if (reg_wr) begin
         if (wr_key && reg_wdata[7:0] == fpes_pkg::KEY_FIRST)
            unlock_q <= fpes_pkg::FPES_KEY1; // see RL1
         else if (wr_key && reg_wdata[7:0] == fpes_pkg::KEY_SECOND &&
                  unlock_q == fpes_pkg::FPES_KEY1)
            unlock_q <= fpes_pkg::FPES_OPEN; // see RL1
         else
            unlock_q <= fpes_pkg::FPES_LOCKED; // see RL23
      end
   end

   // ====================================================
   // control register; rst_b is the power-on reset here
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         start_q  <= 1'b0; // see RL12
         enable_q <= 1'b0;
         erase_q  <= 1'b0;
         op_q     <= 4'h0;
      end else begin
         if (wr_ctrl && !start_q) begin
            enable_q <= reg_wdata[fpes_pkg::BIT_ENABLE];
            erase_q  <= reg_wdata[fpes_pkg::BIT_ERASE];
            op_q     <= reg_wdata[3:0];
         end
         // set-only; writing zero never clears it
         if (go)
            start_q <= 1'b1; // see RL4
         else if (tmr_done)
            start_q <= 1'b0; // see RL4
      end
   end

   // error: set on refused start, cleared only by software writing zero
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         err_q <= 1'b0;
      end else if (start_rq && !go) begin
         err_q <= 1'b1; // see RL6 see RL24
      end else if (wr_ctrl && !reg_wdata[fpes_pkg::BIT_ERR]) begin
         err_q <= 1'b0;
      end
   end

   // ====================================================
   // table page and erase base address
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         page_q <= 8'h00;
         base_q <= 24'h000000;
      end else begin
         if (wr_page)
            page_q <= reg_wdata[7:0];
         if (tbl_wr)
            base_q <= {page_q, tbl_ea}; // see RL22
      end
   end

   // table writes only reach the holding latches
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         latch_wr   <= 1'b0;
         latch_addr <= 24'h000000;
      end else begin
         latch_wr   <= tbl_wr && !start_q; // see RL20
         latch_addr <= {page_q, tbl_ea}; // see RL22
      end
   end

   // ====================================================
   // array strobes, held for the duration, and the stall
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cpu_stall   <= 1'b0;
         flash_word  <= 1'b0;
         flash_row   <= 1'b0;
         flash_block <= 1'b0;
         flash_bulk  <= 1'b0;
         flash_addr  <= 24'h000000;
      end else begin
         if (go) begin
            cpu_stall   <= 1'b1; // see RL3
            flash_word  <= op_d == fpes_pkg::FPES_OP_WORD;
            flash_row   <= op_d == fpes_pkg::FPES_OP_ROW;
            flash_block <= op_d == fpes_pkg::FPES_OP_BLOCK;
            flash_bulk  <= op_d == fpes_pkg::FPES_OP_BULK;
            // align down to the row or block boundary
            if (op_d == fpes_pkg::FPES_OP_BLOCK)
               flash_addr <= base_q - 24'(base_q % 24'(fpes_pkg::BLOCK_BYTES)); // see RL21
            else if (op_d == fpes_pkg::FPES_OP_ROW)
               flash_addr <= base_q - 24'(base_q % 24'(fpes_pkg::ROW_BYTES)); // see RL21
            else
               flash_addr <= base_q;
         end else if (tmr_done) begin
            cpu_stall   <= 1'b0; // see RL3
            flash_word  <= 1'b0;
            flash_row   <= 1'b0;
            flash_block <= 1'b0;
            flash_bulk  <= 1'b0;
         end
      end
   end

   // ====================================================
   // read port; key register reads zero
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            fpes_pkg::ADDR_CTRL:
               reg_rdata <= {start_q, enable_q, err_q, 6'h00, erase_q, 2'h0, op_q}; // see RL13
            fpes_pkg::ADDR_KEY:    reg_rdata <= 16'h0000; // see RL2
            fpes_pkg::ADDR_PAGE:   reg_rdata <= {8'h00, page_q};
            fpes_pkg::ADDR_STATUS: reg_rdata <= {13'h0000, tmr_busy, unlock_q};
            default:               reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ====================================================
   // checks
   // an idle cycle between the keys keeps the checker where it is
   sequence s_unlock;
      wr_key && reg_wdata[7:0] == fpes_pkg::KEY_FIRST
      ##1 !reg_wr
      ##1 wr_key && reg_wdata[7:0] == fpes_pkg::KEY_SECOND;
   endsequence

   a_start_needs_unlock: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL1
      $rose(start_q) |-> $past(unlock_q) == fpes_pkg::FPES_OPEN)
      else $error("start without unlock");
   a_unlock_opens: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL1
      s_unlock |=> unlock_q == fpes_pkg::FPES_OPEN)
      else $error("key pair did not unlock");
   a_key_reads_zero: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL2
      reg_rd && reg_addr == fpes_pkg::ADDR_KEY |=> reg_rdata == 16'h0000)
      else $error("key register readable");
   a_stall_tracks_op: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL3
      cpu_stall == start_q)
      else $error("stall differs from start bit");
   a_start_launches: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL4
      go |=> start_q && cpu_stall)
      else $error("start did not launch");
   a_enable_gates: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL5
      start_rq && !enable_q |=> !start_q && err_q)
      else $error("start ran with enable low");
   a_refused_sets_err: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL24
      start_rq && unlock_q != fpes_pkg::FPES_OPEN |=> err_q && !start_q)
      else $error("refused start not flagged");
   a_bulk_serial: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL11
      $rose(flash_bulk) |-> $past(serial_programming_mode))
      else $error("bulk erase outside serial mode");
   a_word_length: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL9
      $rose(flash_word) |-> flash_word [*2])
      else $error("word program too short");
   a_relock: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL23
      reg_wr && !wr_key |=> unlock_q == fpes_pkg::FPES_LOCKED)
      else $error("checker stayed open");
   a_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL13
      $past(reg_rd) && $past(reg_addr) == fpes_pkg::ADDR_CTRL |->
      (reg_rdata & ~fpes_pkg::CTRL_IMPL_MASK) == 16'h0000)
      else $error("unused bits not zero");

   // ====================================================
   // operation checks; strobes follow the code latched before the start write
   sequence s_released;
      !start_q && !cpu_stall;
   endsequence

   a_stall_busy: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL3
      tmr_busy |-> cpu_stall)
      else $error("timer running without stall");
   a_stall_release: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL3
      tmr_done |=> s_released)
      else $error("stall kept after operation end");
   a_start_holds: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL4
      start_q && !tmr_done |=> start_q)
      else $error("start bit dropped early");
   a_start_timed: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL4
      start_q |-> tmr_busy || tmr_done)
      else $error("start bit set with timer idle");
   a_ctrl_frozen: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL7
      start_q |=> $stable(op_q) && $stable(erase_q) && $stable(enable_q))
      else $error("control changed during operation");
   a_erase_no_prog: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL7
      go && erase_q |=> !flash_word && !flash_row)
      else $error("erase select ran a program");
   a_prog_no_erase: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL7
      go && !erase_q |=> !flash_block && !flash_bulk)
      else $error("program select ran an erase");
   a_block_strobe: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL8
      go && erase_q && op_q == fpes_pkg::OP_BLOCK |=> flash_block && !flash_bulk)
      else $error("block erase not started");
   a_bulk_strobe: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL8
      go && erase_q && op_q == fpes_pkg::OP_BULK && serial_programming_mode |=> flash_bulk)
      else $error("bulk erase not started");
   a_word_strobe: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL9
      go && !erase_q && op_q == fpes_pkg::OP_WORD |=> flash_word && !flash_row)
      else $error("word program not started");
   a_row_strobe: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL9
      go && !erase_q && op_q == fpes_pkg::OP_ROW |=> flash_row && !flash_word)
      else $error("row program not started");
   a_noop_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL10
      go && op_q != fpes_pkg::OP_BULK && op_q != fpes_pkg::OP_BLOCK &&
      op_q != fpes_pkg::OP_WORD && op_q != fpes_pkg::OP_ROW |=>
      !flash_word && !flash_row && !flash_block && !flash_bulk)
      else $error("unimplemented code drove the array");
   a_bulk_refused: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL11
      go && !serial_programming_mode |=> !flash_bulk)
      else $error("bulk erase in self programming");
   a_err_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL6
      err_q && !wr_ctrl |=> err_q)
      else $error("error flag lost");
   a_err_cause: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL6
      !err_q && !(start_rq && !go) |=> !err_q)
      else $error("error flag set without cause");
   a_latch_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL20
      start_q |=> !latch_wr)
      else $error("latch written during operation");
   a_latch_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL22
      tbl_wr && !start_q |=> latch_wr && latch_addr == {$past(page_q), $past(tbl_ea)})
      else $error("latch address wrong");
   a_block_aligned: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL21
      $rose(flash_block) |-> (flash_addr % 24'(fpes_pkg::BLOCK_BYTES)) == 24'h000000)
      else $error("block address not aligned");
   a_row_aligned: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL21
      $rose(flash_row) |-> (flash_addr % 24'(fpes_pkg::ROW_BYTES)) == 24'h000000)
      else $error("row address not aligned");
endmodule
`default_nettype wire

// ### fpes_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// flash array and holding latches, seen from the array side
module fpes_flash_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        latch_wr,
   input  wire logic [23:0] latch_addr,
   input  wire logic        flash_word,
   input  wire logic        flash_row,
   input  wire logic        flash_block,
   input  wire logic        flash_bulk,
   input  wire logic [23:0] flash_addr,
   output var  int          latch_cnt_q,
   output var  logic [23:0] last_latch_q,
   output var  int          ops_q,
   output var  int          overlap_q,
   output var  fpes_pkg::fpes_op_t last_op_q
);
   logic [3:0] strobes;
   logic [3:0] prev_q;
   assign strobes = {flash_bulk, flash_block, flash_row, flash_word};

   // latches only collect data, the array is untouched until an operation
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         latch_cnt_q  <= 0;
         last_latch_q <= 24'h000000;
      end else if (latch_wr) begin
         latch_cnt_q  <= latch_cnt_q + 1;
         last_latch_q <= latch_addr;
      end
   end

   // one operation per rising strobe; more than one strobe is a fault
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prev_q    <= 4'h0;
         ops_q     <= 0;
         overlap_q <= 0;
         last_op_q <= fpes_pkg::FPES_OP_NONE;
      end else begin
         prev_q <= strobes;
         if (strobes != 4'h0 && prev_q == 4'h0) begin
            ops_q     <= ops_q + 1;
            last_op_q <= flash_bulk ? fpes_pkg::FPES_OP_BULK :
                         flash_block ? fpes_pkg::FPES_OP_BLOCK :
                         flash_row ? fpes_pkg::FPES_OP_ROW : fpes_pkg::FPES_OP_WORD;
         end
         if ($countones(strobes) > 1) begin
            overlap_q <= overlap_q + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int CW = 4;
   localparam int CR = 8;
   localparam int CE = 16;
   logic        clk_sys = 1'b0;
   logic        rst_b;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        tbl_wr;
   logic [15:0] tbl_ea;
   logic        serial_mode;
   logic        cpu_stall;
   logic        latch_wr;
   logic [23:0] latch_addr;
   logic        f_word;
   logic        f_row;
   logic        f_block;
   logic        f_bulk;
   logic [23:0] flash_addr;
   int          latch_cnt;
   logic [23:0] last_latch;
   int          ops;
   int          overlap;
   fpes_pkg::fpes_op_t last_op;
   int          errors = 0;
   int          total_checks = 0;

   fpes_seq #(.CYC_WORD(CW), .CYC_ROW(CR), .CYC_ERASE(CE)) dut_u (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tbl_wr(tbl_wr),
      .tbl_ea(tbl_ea), .serial_programming_mode(serial_mode), .cpu_stall(cpu_stall),
      .latch_wr(latch_wr), .latch_addr(latch_addr), .flash_word(f_word),
      .flash_row(f_row), .flash_block(f_block), .flash_bulk(f_bulk),
      .flash_addr(flash_addr));

   fpes_flash_model flash_u (
      .clk_sys(clk_sys), .rst_b(rst_b), .latch_wr(latch_wr), .latch_addr(latch_addr),
      .flash_word(f_word), .flash_row(f_row), .flash_block(f_block),
      .flash_bulk(f_bulk), .flash_addr(flash_addr), .latch_cnt_q(latch_cnt),
      .last_latch_q(last_latch), .ops_q(ops), .overlap_q(overlap), .last_op_q(last_op));

   always #10 clk_sys = ~clk_sys;

   // ====================================================
   // bus tasks
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic tw(input logic [15:0] ea);
      @(posedge clk_sys);
      tbl_ea <= ea;
      tbl_wr <= 1'b1;
      @(posedge clk_sys);
      tbl_wr <= 1'b0;
   endtask

   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   // read data stand only in the cycle after the strobe
   task automatic chk_rd(input string n, input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk(n, {8'h00, e}, {8'h00, reg_rdata});
   endtask

   task automatic unlock_start(input logic [15:0] cfg);
      wr(fpes_pkg::ADDR_KEY, 16'h0055);
      wr(fpes_pkg::ADDR_KEY, 16'h00AA);
      wr(fpes_pkg::ADDR_CTRL, cfg | 16'h8000);
   endtask

   // counts stall cycles; bounded so a stuck stall cannot hang the run
   task automatic wait_idle(output int n);
      n = 0;
      for (int k = 0; k < 100; k++) begin
         @(negedge clk_sys);
         if (cpu_stall !== 1'b1) break;
         n++;
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #200000;
      errors++;
      report_and_stop();
   end

   // ====================================================
   // tests
   // block erase runs before its row is programmed
   logic [7:0] cfg_t [8] = '{8'h42, 8'h01, 8'h03, 8'h4F, 8'h4F, 8'h02, 8'h43, 8'h05};
   int         kind_t [8] = '{3, 2, 1, 4, 0, 0, 0, 0};
   logic [23:0] addr_t [8] = '{24'h123000, 24'h1233C0, 24'h12343E, 24'h12343E,
                               24'h12343E, 24'h12343E, 24'h12343E, 24'h12343E};
   int         cyc_t [5] = '{1, CW, CR, CE, CE};
   logic [7:0] k1_t [3] = '{8'h55, 8'h55, 8'hAA};
   logic [7:0] k2_t [3] = '{8'hAA, 8'hAB, 8'h55};

   initial begin
      int n;
      int ops0;
      int c;
      int l0;
      rst_b = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tbl_wr = 1'b0;
      tbl_ea = 16'h0000;
      serial_mode = 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      chk_rd("ctrl reset", fpes_pkg::ADDR_CTRL, 16'h0000);
      wr(fpes_pkg::ADDR_CTRL, 16'h7FFF);
      chk_rd("ctrl unused bits", fpes_pkg::ADDR_CTRL, 16'h404F);
      $display("test reset_and_layout done");
      wr(fpes_pkg::ADDR_CTRL, 16'h4003);
      wr(fpes_pkg::ADDR_CTRL, 16'hC003);
      chk_rd("start while locked", fpes_pkg::ADDR_CTRL, 16'h6003);
      wr(fpes_pkg::ADDR_CTRL, 16'h0003);
      unlock_start(16'h0003);
      chk_rd("start disabled", fpes_pkg::ADDR_CTRL, 16'h2003);
      chk_rd("key reads zero", fpes_pkg::ADDR_KEY, 16'h0000);
      $display("test refused_starts done");
      for (int i = 0; i < 3; i++) begin
         wr(fpes_pkg::ADDR_CTRL, 16'h4003);
         ops0 = ops;
         wr(fpes_pkg::ADDR_KEY, {8'h00, k1_t[i]});
         if (i == 0) wr(fpes_pkg::ADDR_PAGE, 16'h0001);
         wr(fpes_pkg::ADDR_KEY, {8'h00, k2_t[i]});
         wr(fpes_pkg::ADDR_CTRL, 16'hC003);
         chk_rd("bad unlock", fpes_pkg::ADDR_CTRL, 16'h6003);
         chk("bad unlock ops", 24'h000000, 24'(ops - ops0));
      end
      $display("test relock done");
      wr(fpes_pkg::ADDR_PAGE, 16'h0012);
      ops0 = ops;
      tw(16'h3456);
      repeat (3) @(posedge clk_sys);
      chk("latch count", 24'h000001, 24'(latch_cnt));
      chk("latch address", 24'h123456, last_latch);
      chk("latch no op", 24'h000000, 24'(ops - ops0));
      $display("test latch_write done");
      for (int i = 0; i < 8; i++) begin
         wr(fpes_pkg::ADDR_CTRL, {8'h40, cfg_t[i]});
         serial_mode <= (i == 3);
         l0 = latch_cnt;
         if (i == 1) begin
            for (int k = 0; k < 64; k++) begin
               tw(16'h33C0 + 16'(2 * k));
            end
         end
         ops0 = ops;
         unlock_start({8'h40, cfg_t[i]});
         wait_idle(n);
         c = cyc_t[kind_t[i]];
         chk("op count", 24'(kind_t[i] != 0), 24'(ops - ops0));
         if (kind_t[i] != 0) chk("op kind", 24'(kind_t[i]), 24'(last_op));
         chk("stall length", 24'h000001, 24'(n >= c && n <= c + 2));
         chk("op address", addr_t[i], flash_addr);
         chk("latches", i == 1 ? 24'h000040 : 24'h000000, 24'(latch_cnt - l0));
         chk_rd("ctrl after op", fpes_pkg::ADDR_CTRL, {8'h40, cfg_t[i]});
      end
      chk("no overlap", 24'h000000, 24'(overlap));
      $display("test operations done");
      wr(fpes_pkg::ADDR_CTRL, 16'h4003);
      serial_mode <= 1'b0;
      unlock_start(16'h4003);
      wr(fpes_pkg::ADDR_CTRL, 16'h0000);
      wait_idle(n);
      chk_rd("ctrl kept while busy", fpes_pkg::ADDR_CTRL, 16'h4003);
      $display("test busy_write done");
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      chk_rd("ctrl after reset", fpes_pkg::ADDR_CTRL, 16'h0000);
      $display("test second_reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
